// [src/csli_pkg.sv]
package csli_pkg;
	// register byte offsets
	localparam logic [7:0] CFG_OFF = 8'h00;
	localparam logic [7:0] NODE_OFF = 8'h04;
	localparam logic [7:0] STAT_OFF = 8'h08;
	localparam logic [7:0] IRQ_OFF = 8'h0c;
	localparam logic [7:0] MASK_OFF = 8'h10;
	// cfg fields
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_RATE_LSB = 4;
	localparam int CFG_NMT_LSB = 8;
	localparam int CFG_RST_BIT = 12;
	// status sticky bits
	localparam int EV_WARN = 0;
	localparam int EV_ERRCTL = 1;
	localparam int EV_BUSOFF = 2;
	localparam int EV_IDREJ = 3;
	localparam logic [6:0] NODE_RESET = 7'h01;
	localparam logic [6:0] NODE_MAX = 7'h7f;
	localparam logic [2:0] RATE_RESET = 3'h3;
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int PHASE_MS = 200;
	localparam int PHASE_CYC = CLK_HZ / 1000 * PHASE_MS;
	// single flash: one lit slot, then five dark slots
	localparam int SINGLE_PHASES = 6;
	localparam int RESP = 2'h0;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CSLI_NMT_INIT,
		CSLI_NMT_PREOP,
		CSLI_NMT_STOP,
		CSLI_NMT_OPER
	} csli_nmt_t;
	typedef struct packed {
		logic warn;
		logic errctl;
		logic busoff;
	} csli_err_t;
	typedef struct packed {
		logic red;
		logic green;
	} csli_led_t;
endpackage

// [src/csli_status_led.sv]
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - red dark without errors
// - red single flash on counter warning
// - red double flash on error-control event
// - red steady on while bus-off
// - highest active error pattern wins
// - green blinks in preoperational
// - green single flash when stopped
// - green steady on when operational
// - green dark until connected, during reset
// - red overrides green on conflict
// - eight selectable bit rates
// - node id 1..127, others refused
module csli_status_led #(
	parameter int PHASE_CYCLES = csli_pkg::PHASE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// can controller status
	input wire csli_pkg::csli_err_t can_err,
	input wire logic link_connected,
	input wire logic errctl_event,
	// indicator and configuration out
	output csli_pkg::csli_led_t led,
	output logic [2:0] bit_rate_sel,
	output logic [6:0] node_id,
	output logic irq
);
	// register state
	logic [31:0] cfg_reg;
	logic [6:0] node_reg;
	logic [3:0] stat_reg, stat_next;
	logic [3:0] mask_reg;
	logic errctl_reg;
	// axi handshake state
	logic aw_hold_reg, w_hold_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg, rvalid_reg;
	logic awready_reg, wready_reg, arready_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	// timebase
	logic [23:0] tick_cnt_reg;
	logic [2:0] phase_reg;
	logic [2:0] phase6_reg;
	logic red_reg, green_reg, irq_reg;

	wire aw_take = s_axi_awvalid && awready_reg;
	wire w_take = s_axi_wvalid && wready_reg;
	wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire wr_cfg = wr_fire && awaddr_reg == csli_pkg::CFG_OFF;
	wire wr_node = wr_fire && awaddr_reg == csli_pkg::NODE_OFF;
	wire wr_irq = wr_fire && awaddr_reg == csli_pkg::IRQ_OFF;
	wire wr_mask = wr_fire && awaddr_reg == csli_pkg::MASK_OFF;
	wire wr_stat = wr_fire && awaddr_reg == csli_pkg::STAT_OFF;
	wire wr_map = wr_cfg || wr_node || wr_irq || wr_mask || wr_stat;
	wire [6:0] new_id = wdata_reg[6:0];
	// zero and anything above 7 bits are refused
	wire id_ok = new_id != 7'h00 && wdata_reg[31:7] == 25'h0 &&
		new_id <= csli_pkg::NODE_MAX;
	wire id_rej = wr_node && !(id_ok && wstrb_reg[0]);
	wire ar_take = s_axi_arvalid && arready_reg;
	// ready is a flop, so it is worked out from the next handshake state
	wire aw_hold_next = !wr_fire && (aw_hold_reg || aw_take);
	wire w_hold_next = !wr_fire && (w_hold_reg || w_take);
	wire bvalid_next = wr_fire || (bvalid_reg && !s_axi_bready);
	wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

	// nmt state comes from the config word, fed by the protocol firmware
	wire csli_pkg::csli_nmt_t nmt = csli_pkg::csli_nmt_t'(
		cfg_reg[csli_pkg::CFG_NMT_LSB +: 2]);
	wire node_rst = cfg_reg[csli_pkg::CFG_RST_BIT];

	// blink and double flash share an 8-slot frame of 200 ms slots
	wire tick = tick_cnt_reg == 24'(PHASE_CYCLES - 1);
	wire pat_blink = !phase_reg[0];
	// single flash needs its own 6 slots: 1000 ms dark after the pulse
	wire single_wrap = phase6_reg == 3'(csli_pkg::SINGLE_PHASES - 1);
	wire pat_single = phase6_reg == 3'h0;
	wire pat_double = phase_reg == 3'h0 || phase_reg == 3'h2;

	// red priority mux, highest condition only
	wire red_want = can_err.busoff ? 1'b1 :
		errctl_reg ? pat_double :
		can_err.warn ? pat_single :
		1'b0;
	wire green_on = link_connected && !node_rst;
	wire green_want = !green_on ? 1'b0 :
		nmt == csli_pkg::CSLI_NMT_PREOP ? pat_blink :
		nmt == csli_pkg::CSLI_NMT_STOP ? pat_single :
		nmt == csli_pkg::CSLI_NMT_OPER;
	wire [3:0] events = {id_rej, can_err.busoff, errctl_event, can_err.warn};

	// set beats the write-one clear
	always_comb begin
		stat_next = stat_reg;
		if (wr_irq && wstrb_reg[0])
			stat_next = stat_reg & ~wdata_reg[3:0];
		stat_next = stat_next | events;
	end

	wire [31:0] rd_mux =
		s_axi_araddr == csli_pkg::CFG_OFF ? cfg_reg :
		s_axi_araddr == csli_pkg::NODE_OFF ? {25'h0, node_reg} :
		s_axi_araddr == csli_pkg::STAT_OFF ?
			{27'h0, errctl_reg, can_err.busoff, can_err.warn, irq_reg,
			link_connected} :
		s_axi_araddr == csli_pkg::IRQ_OFF ? {28'h0, stat_reg} :
		s_axi_araddr == csli_pkg::MASK_OFF ? {28'h0, mask_reg} : 32'h0;
	wire rd_map = s_axi_araddr == csli_pkg::CFG_OFF ||
		s_axi_araddr == csli_pkg::NODE_OFF ||
		s_axi_araddr == csli_pkg::STAT_OFF ||
		s_axi_araddr == csli_pkg::IRQ_OFF ||
		s_axi_araddr == csli_pkg::MASK_OFF;

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= csli_pkg::RESP_OK;
		end else begin
			if (aw_take) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (wr_map && !id_rej) ? csli_pkg::RESP_OK :
					csli_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= csli_pkg::RESP_OK;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_map ? csli_pkg::RESP_OK : csli_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_reg <= 32'(csli_pkg::RATE_RESET) << csli_pkg::CFG_RATE_LSB;
			node_reg <= csli_pkg::NODE_RESET;
			mask_reg <= 4'h0;
		end else begin
			if (wr_cfg && wstrb_reg[0])
				cfg_reg[7:0] <= wdata_reg[7:0];
			if (wr_cfg && wstrb_reg[1])
				cfg_reg[15:8] <= wdata_reg[15:8];
			if (wr_node && !id_rej)
				node_reg <= new_id;
			if (wr_mask && wstrb_reg[0])
				mask_reg <= wdata_reg[3:0];
		end
	end

	// ready flags registered so every bus output comes from a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
		end else begin
			awready_reg <= !aw_hold_next && !bvalid_next;
			wready_reg <= !w_hold_next && !bvalid_next;
			arready_reg <= !rvalid_next;
		end
	end

	// error-control event latches until the node is reset
	always_ff @(posedge clk) begin
		if (srst) begin
			errctl_reg <= 1'b0;
			stat_reg <= 4'h0;
			irq_reg <= 1'b0;
		end else begin
			errctl_reg <= errctl_event || (errctl_reg && !node_rst);
			stat_reg <= stat_next;
			irq_reg <= |(stat_next & mask_reg);
		end
	end

	// one counter drives both colours
	always_ff @(posedge clk) begin
		if (srst) begin
			tick_cnt_reg <= 24'h0;
			phase_reg <= 3'h0;
			phase6_reg <= 3'h0;
		end else if (tick) begin
			tick_cnt_reg <= 24'h0;
			phase_reg <= phase_reg + 3'h1;
			phase6_reg <= single_wrap ? 3'h0 : phase6_reg + 3'h1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 24'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			red_reg <= 1'b0;
			green_reg <= 1'b0;
		end else begin
			red_reg <= red_want;
			green_reg <= green_want && !red_want;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign led.red = red_reg;
	assign led.green = green_reg;
	assign bit_rate_sel = cfg_reg[csli_pkg::CFG_RATE_LSB +: 3];
	assign node_id = node_reg;
	assign irq = irq_reg;

	a_red_busoff: assert property (@(posedge clk) disable iff (srst)
		can_err.busoff |=> led.red)
		else $error("red not lit in bus-off");
	a_red_dark: assert property (@(posedge clk) disable iff (srst)
		!can_err.busoff && !errctl_reg && !can_err.warn |=> !led.red)
		else $error("red lit without error");
	a_red_over: assert property (@(posedge clk) disable iff (srst)
		!(led.red && led.green))
		else $error("red and green both lit");
	a_green_dark: assert property (@(posedge clk) disable iff (srst)
		!link_connected |=> !led.green)
		else $error("green lit while disconnected");
	a_green_oper: assert property (@(posedge clk) disable iff (srst)
		link_connected && !node_rst && nmt == csli_pkg::CSLI_NMT_OPER &&
		!red_want |=> led.green)
		else $error("green not lit when operational");
	a_id_range: assert property (@(posedge clk) disable iff (srst)
		node_id != 7'h00)
		else $error("node id zero");
	a_id_hold: assert property (@(posedge clk) disable iff (srst)
		id_rej |=> $stable(node_id))
		else $error("refused id was stored");
	a_ev_sticky: assert property (@(posedge clk) disable iff (srst)
		errctl_event |=> stat_reg[csli_pkg::EV_ERRCTL] && errctl_reg)
		else $error("error-control event lost");
	a_tick_wrap: assert property (@(posedge clk) disable iff (srst)
		tick |=> tick_cnt_reg == 24'h0)
		else $error("timebase did not wrap");
	a_red_single: assert property (@(posedge clk) disable iff (srst)
		can_err.warn && !can_err.busoff && !errctl_reg &&
		phase6_reg != 3'h0 |=> !led.red)
		else $error("red lit outside single flash");
	a_red_double: assert property (@(posedge clk) disable iff (srst)
		errctl_reg && !can_err.busoff && phase_reg[0] |=> !led.red)
		else $error("red lit in a double flash gap");
	a_blink_gap: assert property (@(posedge clk) disable iff (srst)
		nmt == csli_pkg::CSLI_NMT_PREOP && phase_reg[0] |=> !led.green)
		else $error("green lit in a blink gap");
	a_six_slots: assert property (@(posedge clk) disable iff (srst)
		tick && single_wrap |=> phase6_reg == 3'h0)
		else $error("single flash frame not six slots");
	a_rate_hold: assert property (@(posedge clk) disable iff (srst)
		!wr_cfg |=> $stable(bit_rate_sel))
		else $error("bit rate changed without a write");
endmodule // csli_status_led

// [tb/csli_can_model.sv]
`timescale 1ns/10ps
module csli_can_model #(
	parameter int WARN_LVL = 4,
	parameter int OFF_LVL = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bench commands
	input wire logic err_inc,
	input wire logic err_rst,
	input wire logic hb_miss,
	// status to the indicator
	output csli_pkg::csli_err_t can_err,
	output logic errctl_event
);
	logic [7:0] cnt_reg;
	logic hb_reg;
	// saturating, so bus-off holds until the counter is reset
	always_ff @(posedge clk) begin
		if (srst || err_rst)
			cnt_reg <= 8'h00;
		else if (err_inc && cnt_reg != 8'hff)
			cnt_reg <= cnt_reg + 8'h01;
		hb_reg <= hb_miss;
	end
	// one-cycle event per missed heartbeat
	assign errctl_event = hb_miss && !hb_reg;
	assign can_err.warn = cnt_reg >= WARN_LVL;
	assign can_err.errctl = errctl_event;
	assign can_err.busoff = cnt_reg >= OFF_LVL;
endmodule // csli_can_model

// [tb/tb_canopen_status_led_indicator.sv]
`timescale 1ns/10ps
module tb_canopen_status_led_indicator;
	localparam int PH = 4;
	// 24 slots hold whole 6- and 8-slot frames
	localparam int WIN = 24;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic lc = 1'b0, ei = 1'b0, er = 1'b0, hb = 1'b0;
	logic awr, wrd, bv, arr, rv, irq, ev;
	logic [1:0] br, rr, resp;
	logic [31:0] rdt, rdat;
	logic [2:0] rate;
	logic [6:0] nid;
	csli_pkg::csli_err_t ce;
	csli_pkg::csli_led_t led;
	logic [15:0] seed = 16'hd965;
	int err_total = 0;
	int comparisons = 0;
	always #25 clk = ~clk;
	csli_status_led #(.PHASE_CYCLES(PH)) i_dut (.clk(clk), .srst(srst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .can_err(ce),
		.link_connected(lc), .errctl_event(ev), .led(led),
		.bit_rate_sel(rate), .node_id(nid), .irq(irq));
	csli_can_model i_can (.clk(clk), .srst(srst), .err_inc(ei),
		.err_rst(er), .hb_miss(hb), .can_err(ce), .errctl_event(ev));
	function automatic int lit(input int p);
		return p * PH;
	endfunction
	function automatic int gexp(input logic [1:0] m);
		return m == 2'h1 ? lit(WIN / 2) : m == 2'h2 ? lit(WIN / 6) :
			m == 2'h3 ? lit(WIN) : 0;
	endfunction
	function automatic logic [31:0] cfgv(input logic [1:0] m,
		input logic [2:0] r, input logic nr);
		return {19'h0, nr, 2'h0, m, 1'b0, r, 4'h0};
	endfunction
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrd)
				wv <= 1'b0;
			if (bv)
				break;
		end
		bre <= 1'b0;
		resp = br;
		if (k == 40) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic axr(input logic [7:0] a);
		int k;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		rre <= 1'b0;
		resp = rr;
		rdat = rdt;
		if (k == 40) begin
			err_total++;
			close_out();
		end
	endtask
	// window spans whole frames of every pattern, so phase does not matter
	task automatic cnt(output int r, output int g);
		repeat (40) @(posedge clk);
		r = 0;
		g = 0;
		repeat (WIN * PH) begin
			@(posedge clk);
			r += int'(led.red === 1'b1);
			g += int'(led.green === 1'b1);
		end
	endtask
	task automatic bump(input int m);
		repeat (m) begin
			@(posedge clk);
			ei <= 1'b1;
			@(posedge clk);
			ei <= 1'b0;
		end
	endtask
	initial begin
		int r, g, k;
		logic [6:0] id;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("led", 32'h0, {30'h0, led});
		chk("rate", {29'h0, csli_pkg::RATE_RESET}, {29'h0, rate});
		chk("node", {25'h0, csli_pkg::NODE_RESET}, {25'h0, nid});
		axw(csli_pkg::CFG_OFF, cfgv(2'h3, 3'h3, 1'b0));
		cnt(r, g);
		chk("green", 32'h0, g);
		lc <= 1'b1;
		for (k = 0; k < 4; k++) begin
			axw(csli_pkg::CFG_OFF, cfgv(k[1:0], 3'h3, 1'b0));
			cnt(r, g);
			chk("green", gexp(k[1:0]), g);
			chk("red", 32'h0, r);
		end
		axw(csli_pkg::CFG_OFF, cfgv(2'h3, 3'h3, 1'b1));
		cnt(r, g);
		chk("green", 32'h0, g);
		$display("test run states done");
		axw(csli_pkg::CFG_OFF, cfgv(2'h3, 3'h3, 1'b0));
		bump(4);
		cnt(r, g);
		chk("red", lit(WIN / 6), r);
		hb <= 1'b1;
		@(posedge clk);
		hb <= 1'b0;
		cnt(r, g);
		chk("red", lit(WIN / 4), r);
		bump(4);
		cnt(r, g);
		chk("red", lit(WIN), r);
		chk("green", 32'h0, g);
		er <= 1'b1;
		@(posedge clk);
		er <= 1'b0;
		axw(csli_pkg::CFG_OFF, cfgv(2'h3, 3'h3, 1'b1));
		axw(csli_pkg::CFG_OFF, cfgv(2'h3, 3'h3, 1'b0));
		cnt(r, g);
		chk("red", 32'h0, r);
		chk("green", lit(WIN), g);
		$display("test error patterns done");
		for (k = 0; k < 8; k++) begin
			axw(csli_pkg::CFG_OFF, cfgv(2'h3, k[2:0], 1'b0));
			repeat (2) @(posedge clk);
			chk("rate", k, {29'h0, rate});
		end
		axw(csli_pkg::MASK_OFF, 32'h8);
		for (k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			id = k == 0 ? 7'h7f : k == 1 ? 7'h01 : seed[6:0] % 7'h7f + 7'h01;
			axw(csli_pkg::NODE_OFF, {25'h0, id});
			chk("resp", {30'h0, csli_pkg::RESP_OK}, {30'h0, resp});
			repeat (2) @(posedge clk);
			chk("node", {25'h0, id}, {25'h0, nid});
		end
		for (k = 0; k < 2; k++) begin
			axw(csli_pkg::NODE_OFF, k == 0 ? 32'h80 : 32'h0);
			chk("resp", {30'h0, csli_pkg::RESP_SLVERR}, {30'h0, resp});
			repeat (2) @(posedge clk);
			chk("node", {25'h0, id}, {25'h0, nid});
		end
		chk("irq", 32'h1, {31'h0, irq});
		axr(csli_pkg::IRQ_OFF);
		chk("irq status", 32'h1, {31'h0, rdat[3]});
		axw(csli_pkg::IRQ_OFF, 32'h8);
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		axr(8'h14);
		chk("resp", {30'h0, csli_pkg::RESP_SLVERR}, {30'h0, resp});
		chk("rdata", 32'h0, rdat);
		$display("test registers done");
		close_out();
	end
endmodule // tb_canopen_status_led_indicator
